// ### cluster_adapter_link_csr.sv
// Link control/status register and PCI error flags of the adapter.
// Assumes PCI target logic presents one-cycle register strobes and that
// error, FIFO and port events arrive already in the PCI clock domain,
// except the virtual hub strap and online vector, which are synchronised.
`timescale 1ns/10ps
module cluster_adapter_link_csr (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Transmit window access
  input  wire logic [26:0] win_offset_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        status_wr_in,
  // Cluster side events
  input  wire logic        port_change_in,
  input  wire logic        flagged_write_in,
  input  wire logic        tpe_event_in,
  input  wire logic        rpe_event_in,
  input  wire logic        tx_fifo_nonempty_in,
  input  wire logic        rx_fifo_nonempty_in,
  input  wire logic [7:0]  node_online_in,
  input  wire logic        virtual_hub_in,
  // PCI side events
  input  wire logic        addr_parity_err_in,
  input  wire logic        is_master_in,
  input  wire logic        serr_enable_in,
  input  wire logic        target_data_par_in,
  input  wire logic        master_abort_in,
  input  wire logic        target_abort_in,
  input  wire logic        perr_seen_in,
  input  wire logic        perr_response_in,
  // Results
  output logic [31:0]      reg_rdata_out,
  output logic             reg_rvalid_out,
  output logic [31:0]      pci_status_out,
  output logic             serr_out,
  output logic             irq_out,
  output logic             link_ok_out,
  output logic             use_sg_table_out,
  output logic             cluster_rst_out,
  output logic [1:0]       region_out
);
  link_csr_pkg::region_e region_q;
  logic        lcs_hit;
  logic        lcs_wr;
  logic        put_d;
  logic        rst_req;
  logic [7:0]  online_s1_q;
  logic [7:0]  online_q;
  logic        vhub_s1_q;
  logic        vhub_q;
  logic        sg_en_q;
  logic        put_q;
  logic [3:0]  enables_q;
  logic        rsv13_q;
  logic [2:0]  rsv_hi_q;
  logic        port_chg_f;
  logic        cl_int_f;
  logic        tpe_f;
  logic        rpe_f;
  logic        addr_par;
  logic        perr_master;
  logic        tpe_set;
  logic        rpe_set;
  logic        summary;
  logic [31:0] lcs_view;
  logic [31:0] status_q;
  logic [31:0] status_d;

  // One write-data bit qualified by the register write strobe
  function automatic logic wr_bit(input logic wr, input logic [31:0] d,
                                  input int pos);
    return wr && d[pos];
  endfunction

  // Register hit decode is combinational so writes take effect in one cycle
  assign lcs_hit = (win_offset_in == link_csr_pkg::LCS_OFFSET);
  assign lcs_wr  = reg_wr_in && lcs_hit;
  // Next hold value and reset request, so link OK drops in the same cycle
  assign put_d   = lcs_wr ? reg_wdata_in[link_csr_pkg::PUT_BIT] : put_q;
  assign rst_req = wr_bit(lcs_wr, reg_wdata_in, link_csr_pkg::IF_RST_BIT);

  region_decode u_region (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .offset_in  (win_offset_in),
    .region_out (region_q)
  );

  // Pin-level online vector and strap cross in through two flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      online_s1_q <= 8'h00;
      online_q    <= 8'h00;
      vhub_s1_q   <= 1'b0;
      vhub_q      <= 1'b0;
    end else begin
      online_s1_q <= node_online_in;
      online_q    <= online_s1_q;
      vhub_s1_q   <= virtual_hub_in;
      vhub_q      <= vhub_s1_q;
    end
  end

  // Writable control bits; read-only fields simply have no write path
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sg_en_q   <= 1'b0;
      put_q     <= link_csr_pkg::LCS_RESET[link_csr_pkg::PUT_BIT];
      enables_q <= 4'h0;
      rsv13_q   <= 1'b0;
      rsv_hi_q  <= 3'h0;
    end else if (lcs_wr) begin
      sg_en_q   <= reg_wdata_in[link_csr_pkg::SG_EN_BIT];
      put_q     <= reg_wdata_in[link_csr_pkg::PUT_BIT];
      enables_q <= reg_wdata_in[link_csr_pkg::PORT_IE_BIT:
                                link_csr_pkg::RPE_IE_BIT];
      rsv13_q   <= reg_wdata_in[link_csr_pkg::RSV13_BIT];
      rsv_hi_q  <= reg_wdata_in[link_csr_pkg::RSV_HI_MSB:
                                link_csr_pkg::RSV_HI_LSB];
    end
  end

  // Address parity not as master is also a potential transmit error
  assign addr_par = addr_parity_err_in && !is_master_in;
  assign tpe_set  = tpe_event_in || (addr_par && serr_enable_in);
  // Target PERR only counts while this device masters the write
  assign perr_master = perr_seen_in && perr_response_in && is_master_in;
  assign rpe_set  = rpe_event_in || perr_master;

  // Port change requests only count while their enable is on
  w1c_flag u_port_chg (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .set_in   (port_change_in && enables_q[3]),
    .clr_in   (wr_bit(lcs_wr, reg_wdata_in, link_csr_pkg::PORT_CHG)),
    .flag_out (port_chg_f)
  );

  w1c_flag u_cl_int (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .set_in   (flagged_write_in),
    .clr_in   (wr_bit(lcs_wr, reg_wdata_in, link_csr_pkg::CL_INT_BIT)),
    .flag_out (cl_int_f)
  );

  w1c_flag u_rpe (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .set_in   (rpe_set),
    .clr_in   (wr_bit(lcs_wr, reg_wdata_in, link_csr_pkg::RPE_BIT)),
    .flag_out (rpe_f)
  );

  w1c_flag u_tpe (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .set_in   (tpe_set),
    .clr_in   (wr_bit(lcs_wr, reg_wdata_in, link_csr_pkg::TPE_BIT)),
    .flag_out (tpe_f)
  );

  // Summary covers raw pending conditions, not masked ones
  assign summary = tpe_f | rpe_f | cl_int_f | port_chg_f;

  // Read view; writes never reach bits 31:27, 26:19, 15, 10, 9, 2
  always_comb begin
    lcs_view = 32'h00000000;
    lcs_view[link_csr_pkg::ONLINE_MSB:link_csr_pkg::ONLINE_LSB] = online_q;
    lcs_view[link_csr_pkg::RSV_HI_MSB:link_csr_pkg::RSV_HI_LSB] = rsv_hi_q;
    lcs_view[link_csr_pkg::SUMMARY_BIT] = summary;
    lcs_view[link_csr_pkg::PORT_CHG]    = port_chg_f;
    lcs_view[link_csr_pkg::RSV13_BIT]   = rsv13_q;
    lcs_view[link_csr_pkg::SG_EN_BIT]   = sg_en_q;
    lcs_view[link_csr_pkg::PUT_BIT]     = put_q;
    lcs_view[link_csr_pkg::TX_PEND_BIT] = tx_fifo_nonempty_in;
    lcs_view[link_csr_pkg::RX_PEND_BIT] = rx_fifo_nonempty_in;
    lcs_view[link_csr_pkg::CL_INT_BIT]  = cl_int_f;
    lcs_view[link_csr_pkg::PORT_IE_BIT:link_csr_pkg::RPE_IE_BIT] = enables_q;
    lcs_view[link_csr_pkg::VHUB_BIT]    = vhub_q;
    lcs_view[link_csr_pkg::RPE_BIT]     = rpe_f;
    lcs_view[link_csr_pkg::TPE_BIT]     = tpe_f;
  end

  // Read data registered; unmapped offsets answer zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out  <= 32'h00000000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= lcs_hit ? lcs_view : 32'h00000000;
      end
    end
  end

  // PCI status sticky bits, set wins over a same-cycle write-one clear
  always_comb begin
    status_d = status_q;
    if (status_wr_in) begin
      status_d = status_q & ~reg_wdata_in;
    end
    if (addr_par) begin
      status_d[link_csr_pkg::ST_ANY_PAR] = 1'b1;
      // Bit 30 follows the SERR assertion, never cleared by an event
      if (serr_enable_in) begin
        status_d[link_csr_pkg::ST_ADR_PAR] = 1'b1;
      end
    end
    if (target_data_par_in) begin
      status_d[link_csr_pkg::ST_ANY_PAR] = 1'b1;
    end
    if (master_abort_in) begin
      status_d[link_csr_pkg::ST_MABORT] = 1'b1;
    end
    if (target_abort_in) begin
      status_d[link_csr_pkg::ST_TABORT] = 1'b1;
    end
    if (perr_master) begin
      status_d[link_csr_pkg::ST_MPERR] = 1'b1;
    end
    // Only the implemented sticky bits can hold a value
    status_d = status_d & 32'hF1000000;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_q <= link_csr_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Serr pulses the cycle after a qualifying address parity error
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serr_out <= 1'b0;
    end else begin
      serr_out <= addr_par && serr_enable_in;
    end
  end

  // Interrupt request: each pending bit gated by its own enable
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= (port_chg_f && enables_q[3]) ||
                 (cl_int_f   && enables_q[2]) ||
                 (tpe_f      && enables_q[1]) ||
                 (rpe_f      && enables_q[0]);
    end
  end

  // Link OK held low while the power-up test hold is set
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_ok_out <= 1'b0;
    end else begin
      link_ok_out <= !put_d && !rst_req;
    end
  end

  // Cluster-side reset pulse; PCI-side registers here are not touched
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cluster_rst_out <= 1'b0;
    end else begin
      cluster_rst_out <= rst_req;
    end
  end

  // Translation select and region, straight from flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      use_sg_table_out <= 1'b0;
    end else begin
      use_sg_table_out <= sg_en_q;
    end
  end

  assign pci_status_out = status_q;
  assign region_out     = region_q;
endmodule

// ### link_csr_pkg.sv
// Package for the link control/status register bank.
// Assumes a single PCI clock domain; no other package is used.
package link_csr_pkg;
  // Transmit window map, byte offsets from the window base
  localparam logic [26:0] PCT_BASE    = 27'h0000000;
  localparam logic [26:0] PCT_LAST    = 27'h003FFFF;
  localparam logic [26:0] CSR_BASE    = 27'h0040000;
  localparam logic [26:0] CSR_LAST    = 27'h0041FFF;
  localparam logic [26:0] XMIT_BASE   = 27'h0042000;
  localparam logic [26:0] WINDOW_LAST = 27'h7FFFFFF;
  localparam logic [26:0] LCS_OFFSET  = 27'h0040000;
  // Field positions of link_control_status
  localparam int ONLINE_LSB  = 19;
  localparam int ONLINE_MSB  = 26;
  localparam int RSV_HI_LSB  = 16;
  localparam int RSV_HI_MSB  = 18;
  localparam int SUMMARY_BIT = 15;
  localparam int PORT_CHG    = 14;
  localparam int RSV13_BIT   = 13;
  localparam int SG_EN_BIT   = 12;
  localparam int PUT_BIT     = 11;
  localparam int TX_PEND_BIT = 10;
  localparam int RX_PEND_BIT = 9;
  localparam int IF_RST_BIT  = 8;
  localparam int CL_INT_BIT  = 7;
  localparam int PORT_IE_BIT = 6;
  localparam int CL_IE_BIT   = 5;
  localparam int TPE_IE_BIT  = 4;
  localparam int RPE_IE_BIT  = 3;
  localparam int VHUB_BIT    = 2;
  localparam int RPE_BIT     = 1;
  localparam int TPE_BIT     = 0;
  // Reset value: only the power-up test hold comes up set
  localparam logic [31:0] LCS_RESET = 32'h00000800;
  // PCI status bit positions
  localparam int ST_ANY_PAR  = 31;
  localparam int ST_ADR_PAR  = 30;
  localparam int ST_MABORT   = 29;
  localparam int ST_TABORT   = 28;
  localparam int ST_MPERR    = 24;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  // Address decode regions
  typedef enum logic [1:0] {
    REGION_PCT  = 2'b00,
    REGION_CSR  = 2'b01,
    REGION_XMIT = 2'b10
  } region_e;
endpackage

// ### w1c_flag.sv
// One sticky event flag cleared by writing one.
// Assumes set and clear are synchronous to clk_in.
`timescale 1ns/10ps
module w1c_flag (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  // Set beats clear so an event in the clear cycle survives
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clr_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule

// ### region_decode.sv
// Transmit window region decoder, registered.
// Assumes window offset arrives synchronous to clk_in.
`timescale 1ns/10ps
module region_decode (
  input  wire logic                     clk_in,
  input  wire logic                     rstn_in,
  input  wire logic [26:0]              offset_in,
  output link_csr_pkg::region_e         region_out
);
  // Three contiguous regions, window upper limit is the offset width
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      region_out <= link_csr_pkg::REGION_PCT;
    end else if (offset_in <= link_csr_pkg::PCT_LAST) begin
      region_out <= link_csr_pkg::REGION_PCT;
    end else if (offset_in <= link_csr_pkg::CSR_LAST) begin
      region_out <= link_csr_pkg::REGION_CSR;
    end else begin
      region_out <= link_csr_pkg::REGION_XMIT;
    end
  end
endmodule

// ### link_csr_checker_sva.sv
// Concurrent checks on the link control/status register bank.
// Assumes the top module's ports only, one clock, async active-low reset.
`timescale 1ns/10ps
module link_csr_checker (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [26:0] win_offset_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        tx_fifo_nonempty_in,
  input wire logic        rx_fifo_nonempty_in,
  input wire logic        is_master_in,
  input wire logic        serr_enable_in,
  input wire logic        addr_parity_err_in,
  input wire logic        target_data_par_in,
  input wire logic        master_abort_in,
  input wire logic        target_abort_in,
  input wire logic        perr_seen_in,
  input wire logic        perr_response_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [31:0] pci_status_out,
  input wire logic        serr_out,
  input wire logic        link_ok_out,
  input wire logic        cluster_rst_out,
  input wire logic [1:0]  region_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Register read and interface reset pulse as named steps
  sequence s_csr_rd;
    reg_rd_in && win_offset_in == 27'h0040000;
  endsequence
  sequence s_rst_wr;
    reg_wr_in && reg_wdata_in[8] && win_offset_in == 27'h0040000;
  endsequence
  sequence s_rst_pulse;
    cluster_rst_out ##1 !cluster_rst_out;
  endsequence
  // Expected region of a window offset
  function automatic logic [1:0] region_of(input logic [26:0] off);
    if (off < 27'h0040000) return 2'h0;
    if (off < 27'h0042000) return 2'h1;
    return 2'h2;
  endfunction
  AST_SUMMARY: assert property (s_csr_rd |=> reg_rdata_out[15] ==
    (reg_rdata_out[14] | reg_rdata_out[7] | reg_rdata_out[1] |
     reg_rdata_out[0])) else $error("summary bit wrong");
  AST_RSVD_ZERO: assert property (s_csr_rd |=>
    reg_rdata_out[31:27] == 5'h00) else $error("reserved bits set");
  AST_PENDING: assert property (s_csr_rd |=>
    reg_rdata_out[10:9] == $past({tx_fifo_nonempty_in, rx_fifo_nonempty_in}))
    else $error("fifo pending bits wrong");
  // A lone reset write gives exactly one cycle of pulse; repeats stretch it
  AST_IF_RESET: assert property ((s_rst_wr ##1 !(reg_wr_in &&
    reg_wdata_in[8] && win_offset_in == 27'h0040000)) |-> s_rst_pulse)
    else $error("interface reset pulse wrong");
  AST_LINK_HOLD: assert property (cluster_rst_out |-> !link_ok_out)
    else $error("link ok during reset pulse");
  AST_ADDR_PAR: assert property ((addr_parity_err_in &&
    !is_master_in && serr_enable_in) |=> pci_status_out[31:30] == 2'b11)
    else $error("address parity status wrong");
  AST_SERR: assert property ((addr_parity_err_in &&
    !is_master_in && serr_enable_in) |=> serr_out)
    else $error("serr not pulsed");
  AST_TGT_PAR: assert property (target_data_par_in |=>
    pci_status_out[31]) else $error("data parity not flagged");
  AST_MABORT: assert property (master_abort_in |=>
    pci_status_out[29]) else $error("master abort not flagged");
  AST_TABORT: assert property (target_abort_in |=>
    pci_status_out[28]) else $error("target abort not flagged");
  AST_MASTER_PERR: assert property ((perr_seen_in &&
    perr_response_in && is_master_in) |=> pci_status_out[24])
    else $error("master parity error not flagged");
  AST_REGION: assert property (1'b1 |=>
    region_out == region_of($past(win_offset_in)))
    else $error("region decode wrong");
endmodule

bind cluster_adapter_link_csr link_csr_checker chk (.*);

// ### pci_host_model.sv
// Host side of the register window: one-cycle strobes, fixed-latency reads.
// Assumes the register bank answers a read one cycle after the strobe.
`timescale 1ns/10ps
module pci_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic [26:0]      win_offset_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic             status_wr_out,
  output logic [31:0]      wdata_out
);
  initial begin
    win_offset_out = 27'h0000000;
    {reg_wr_out, reg_rd_out, status_wr_out} = 3'h0;
    wdata_out = 32'h00000000;
  end
  // Kind 0 write, 1 read, 2 status clear; strobes change on falling edges
  task automatic access(input logic [1:0] kind, input logic [26:0] off,
                        input logic [31:0] d, output logic [31:0] q);
    @(negedge clk_in);
    win_offset_out = off;
    wdata_out = d;
    reg_wr_out = (kind == 2'h0);
    reg_rd_out = (kind == 2'h1);
    status_wr_out = (kind == 2'h2);
    @(negedge clk_in);
    {reg_wr_out, reg_rd_out, status_wr_out} = 3'h0;
    wdata_out = ~d; // Released data never shows the stale word
    q = rvalid_in ? rdata_in : 32'hXXXXXXXX; // Missing answer never matches
  endtask
endmodule

// ### cluster_adapter_link_csr_bench.sv
// Self-checking bench for the link control/status register bank.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/10ps
module cluster_adapter_link_csr_bench;
  logic clk_in = 1'b0, rstn_in = 1'b0;
  logic [26:0] win_offset_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, pci_status_out, rd_q;
  logic reg_wr_in, reg_rd_in, status_wr_in, reg_rvalid_out, serr_out;
  logic irq_out, link_ok_out, use_sg_table_out, cluster_rst_out;
  logic [1:0] region_out;
  logic port_change_in = 0, flagged_write_in = 0, tpe_event_in = 0;
  logic rpe_event_in = 0, tx_fifo_nonempty_in = 0, rx_fifo_nonempty_in = 0;
  logic [7:0] node_online_in = 8'h00;
  logic virtual_hub_in = 0, addr_parity_err_in = 0, is_master_in = 0;
  logic serr_enable_in = 0, target_data_par_in = 0, master_abort_in = 0;
  logic target_abort_in = 0, perr_seen_in = 0, perr_response_in = 0;
  int err_total = 0, samples_checked = 0, cycles = 0;
  logic [26:0] offs [6] = '{27'h0, 27'h3FFFF, 27'h41000, 27'h41FFF,
                            27'h42000, 27'h7FFFFFF};
  logic [1:0] regs [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

  always #12.5 clk_in = ~clk_in;
  cluster_adapter_link_csr dut (.*);
  pci_host_model host (.clk_in(clk_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out), .win_offset_out(win_offset_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .status_wr_out(status_wr_in), .wdata_out(reg_wdata_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One-cycle event pulse launched on a falling edge
  task automatic pulse(ref logic s);
    @(negedge clk_in);
    s = 1'b1;
    @(negedge clk_in);
    s = 1'b0;
  endtask
  task automatic rd(input logic [26:0] off);
    host.access(2'h1, off, 32'h0, rd_q);
  endtask
  task automatic wr(input logic [31:0] d);
    logic [31:0] q;
    host.access(2'h0, 27'h0040000, d, q);
  endtask
  task automatic st_clr(input logic [31:0] d);
    logic [31:0] q;
    host.access(2'h2, 27'h0, d, q);
  endtask

  // Hang guard: far above the fewer than 100 cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    rd(27'h40000);
    check(rd_q, 32'h00000800);
    // Window split: only the CSR offset answers, others read zero
    for (int i = 0; i < 6; i++) begin
      rd(offs[i]);
      check(rd_q, 32'h0);
      check({30'h0, region_out}, {30'h0, regs[i]});
    end
    // All ones but bit 8: only plain storage bits take it
    wr(32'hFFFFFEFF);
    rd(27'h40000);
    check(rd_q, 32'h00073878);
    check({31'h0, use_sg_table_out}, 32'h1);
    check({31'h0, link_ok_out}, 32'h0);
    wr(32'h0);
    @(negedge clk_in);
    check({31'h0, link_ok_out}, 32'h1);
    check({31'h0, use_sg_table_out}, 32'h0);
    // Events with every enable clear: flags yes, port change and irq no
    pulse(port_change_in);
    pulse(tpe_event_in);
    rd(27'h40000);
    check(rd_q, 32'h00008001);
    check({31'h0, irq_out}, 32'h0);
    wr(32'h1);
    // Enabled events, strapped levels given time to synchronise
    node_online_in = 8'hA5;
    virtual_hub_in = 1'b1;
    tx_fifo_nonempty_in = 1'b1;
    wr(32'h78);
    pulse(port_change_in);
    pulse(rpe_event_in);
    pulse(flagged_write_in);
    pulse(tpe_event_in);
    rd(27'h40000);
    check(rd_q, 32'h0528C4FF);
    check({31'h0, irq_out}, 32'h1);
    wr(32'h79);
    rd(27'h40000);
    check(rd_q, 32'h0528C4FE);
    tx_fifo_nonempty_in = 1'b0;
    rx_fifo_nonempty_in = 1'b1;
    wr(32'h40FA);
    rd(27'h40000);
    check(rd_q, 32'h0528027C);
    check({31'h0, irq_out}, 32'h0);
    // Interface reset: one-cycle pulse, link ok dropped meanwhile
    wr(32'h100);
    check({30'h0, cluster_rst_out, link_ok_out}, 32'h2);
    @(negedge clk_in);
    check({30'h0, cluster_rst_out, link_ok_out}, 32'h1);
    // PCI-side error flags
    serr_enable_in = 1'b1;
    pulse(addr_parity_err_in);
    check(pci_status_out, 32'hC0000000);
    check({31'h0, serr_out}, 32'h1);
    st_clr(32'hC0000000);
    check(pci_status_out, 32'h0);
    pulse(target_data_par_in);
    check(pci_status_out, 32'h80000000);
    st_clr(32'h80000000);
    is_master_in = 1'b1;
    perr_response_in = 1'b1;
    pulse(master_abort_in);
    pulse(target_abort_in);
    pulse(perr_seen_in);
    check(pci_status_out, 32'h31000000);
    // Path error flags from the PCI side, enables off so no request
    rd(27'h40000);
    check(rd_q, 32'h05288207);
    check({31'h0, irq_out}, 32'h0);
    // Mid-run reset: outputs drop, register comes back to reset value
    node_online_in = 8'h00;
    virtual_hub_in = 1'b0;
    rx_fifo_nonempty_in = 1'b0;
    @(negedge clk_in);
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    check(pci_status_out, 32'h0);
    check(reg_rdata_out, 32'h0);
    check({24'h0, serr_out, irq_out, link_ok_out, cluster_rst_out,
           use_sg_table_out, reg_rvalid_out, region_out}, 32'h0);
    rstn_in = 1'b1;
    rd(27'h40000);
    check(rd_q, 32'h00000800);
    check({31'h0, link_ok_out}, 32'h0);
    end_of_test();
  end
endmodule
